// ---- design/sdpf_pkg.sv ----
// Shared constants for the sinc decimation and post filter block.
// Assumes one clock, a synchronous active-high reset and a modulator tick per divided clock.
package sdpf_pkg;
    // Filter type codes
    localparam logic [1:0]  FT_SINC5AVG   = 2'h0;
    localparam logic [1:0]  FT_SINC5      = 2'h1;
    localparam logic [1:0]  FT_SINC3      = 2'h2;
    // Post filter selection codes
    localparam logic [2:0]  PS_NONE       = 3'h0;
    localparam logic [2:0]  PS_40MS       = 3'h1;
    localparam logic [2:0]  PS_50MS       = 3'h2;
    localparam logic [2:0]  PS_60MS       = 3'h3;
    localparam logic [2:0]  PS_AVG16      = 3'h4;
    // Decimation arithmetic
    localparam logic [31:0] SINC_BASE     = 32'h0000_0020;
    localparam logic [31:0] ORDER_SINC5   = 32'h0000_0005;
    localparam logic [31:0] ORDER_SINC3   = 32'h0000_0003;
    localparam logic [15:0] FS_ONE        = 16'h0001;
    localparam logic [15:0] FS_TWO        = 16'h0002;
    localparam logic [15:0] FS_STEP       = 16'h0004;
    localparam logic [15:0] FS_S5_MAX     = 16'h0100;
    localparam logic [15:0] FS_AVG_BASE   = 16'h0004;
    // Processing cycles
    localparam logic [31:0] PT_S5_FS1     = 32'h0000_0062;
    localparam logic [31:0] PT_S5_FS2     = 32'h0000_0072;
    localparam logic [31:0] PT_S5         = 32'h0000_0060;
    localparam logic [31:0] PT_S3         = 32'h0000_005C;
    localparam logic [31:0] PT_AVG_FS4    = 32'h0000_0060;
    localparam logic [31:0] PT_AVG        = 32'h0000_0062;
    localparam logic [31:0] PT_SEQ_LOWFS  = 32'h0000_0040;
    localparam logic [31:0] PT_SEQ        = 32'h0000_0000;
    // Post filter lengths from conversion time at the nominal sinc rate
    localparam int          SINC_POST_SPS = 1200;
    localparam int          POST40_MS     = 40;
    localparam int          POST50_MS     = 50;
    localparam int          POST60_MS     = 60;
    localparam int          MS_PER_S      = 1000;
    localparam logic [31:0] POST40_WORDS  = 32'(POST40_MS * SINC_POST_SPS / MS_PER_S);
    localparam logic [31:0] POST50_WORDS  = 32'(POST50_MS * SINC_POST_SPS / MS_PER_S);
    localparam logic [31:0] POST60_WORDS  = 32'(POST60_MS * SINC_POST_SPS / MS_PER_S);
    localparam logic [31:0] AVG16_WORDS   = 32'h0000_0010;
    localparam logic [31:0] ONE32         = 32'h0000_0001;
    // Output word
    localparam int          OUT_BITS      = 24;
    localparam int          CIC_ACC_BITS  = 68;

    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b001,
        ST_SETTLE = 3'b010,
        ST_RUN    = 3'b100
    } sdpf_phase_t;
endpackage

// ---- design/sdpf_cic.sv ----
// Cascaded integrator-comb core of third or fifth order on a one-bit stream.
// Assumes sampleValid once per divided clock and decStrobe once per decimation step.
module sdpf_cic
    import sdpf_pkg::*;
#(
    parameter int ACC_W = CIC_ACC_BITS
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Control
    input  wire logic             clear,
    input  wire logic             order5,
    input  wire logic             decStrobe,
    // Modulator stream
    input  wire logic             sampleValid,
    input  wire logic             sampleBit,
    // Comb output
    output logic      [ACC_W-1:0] result
);
    localparam int STAGES = 5;

    typedef struct packed
    {
        logic [STAGES-1:0][ACC_W-1:0] integ;
        logic [STAGES-1:0][ACC_W-1:0] combDly;
        logic [ACC_W-1:0]             result;
    } sdpf_cic_state_t;

    sdpf_cic_state_t s;
    sdpf_cic_state_t next_s;

    initial
    begin
        if (ACC_W < 66)
            $error("sdpf_cic: accumulator too narrow for the largest gain");
    end

    // Modular arithmetic makes integrator wrap harmless as long as ACC_W covers the gain
    always_comb
    begin
        logic [ACC_W-1:0] step;
        logic [ACC_W-1:0] c;
        int               used;
        next_s = s;
        step   = sampleBit ? ACC_W'(1) : '1;
        used   = order5 ? 5 : 3;
        c      = order5 ? s.integ[4] : s.integ[2];
        if (clear)
        begin
            next_s = '0;
        end
        else
        begin
            if (sampleValid)
            begin
                next_s.integ[0] = s.integ[0] + step;
                for (int i = 1; i < STAGES; i++)
                begin
                    next_s.integ[i] = s.integ[i] + s.integ[i-1];
                end
            end
            if (decStrobe)
            begin
                for (int i = 0; i < STAGES; i++)
                begin
                    if (i < used)
                    begin
                        next_s.combDly[i] = c;
                        c = c - s.combDly[i];
                    end
                end
                next_s.result = c;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign result = s.result;
endmodule

// ---- design/sdpf_filter.sv ----
// Sinc decimation, averaging and post filter stage with settling and sequencer timing.
// Assumes modBitValid marks one divided-clock period; configuration arrives as write pulses.
module sdpf_filter
    import sdpf_pkg::*;
#(
    parameter int NCH = 16,
    parameter int CW  = 4
)
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Modulator stream
    input  wire logic            modBitValid,
    input  wire logic            modBit,
    // Filter configuration
    input  wire logic            cfgWrite,
    input  wire logic [1:0]      cfgFilterType,
    input  wire logic [15:0]     cfgDecimation,
    input  wire logic [2:0]      cfgPostSel,
    // Channels
    input  wire logic [NCH-1:0]  chanEnable,
    input  wire logic [7:0]      chanRepeat,
    input  wire logic            chanSelWrite,
    input  wire logic [CW-1:0]   chanSel,
    // Conversion output
    output logic                 dataValid,
    output logic [OUT_BITS-1:0]  dataWord,
    output logic [CW-1:0]        dataChannel,
    // Status
    output logic                 cfgError,
    output logic                 seqActive,
    output logic                 settling,
    output logic [1:0]           activeFilterType,
    output logic [15:0]          activeDecimation
);
    localparam int ACC_BITS = 48;

    typedef struct packed
    {
        sdpf_phase_t         phase;
        logic [1:0]          fType;
        logic [15:0]         fs;
        logic [2:0]          post;
        logic                cfgErr;
        logic [NCH-1:0]      mask;
        logic [CW-1:0]       chan;
        logic                seq;
        logic [31:0]         rate;
        logic [31:0]         decCnt;
        logic [31:0]         wordCnt;
        logic [31:0]         group;
        logic [31:0]         inGroup;
        logic [7:0]          repLeft;
        logic [6:0]          sincShift;
        logic [5:0]          grpShift;
        logic [ACC_BITS-1:0] accum;
        logic                clrCic;
        logic                decStb;
        logic                dataValid;
        logic [OUT_BITS-1:0] dataWord;
        logic [CW-1:0]       dataChan;
    } sdpf_core_state_t;

    sdpf_core_state_t s;
    sdpf_core_state_t next_s;
    logic [CIC_ACC_BITS-1:0] cicResult;

    initial
    begin
        if (NCH < 2 || (1 << CW) < NCH)
            $error("sdpf_filter: channel index too narrow or too few channels");
    end

    function automatic logic fsLegal(input logic [1:0] ft, input logic [15:0] fs);
        logic mul4;
        mul4 = (fs[1:0] == 2'h0) && (fs >= FS_STEP);
        case (ft)
            FT_SINC5:    fsLegal = (fs == FS_ONE) || (fs == FS_TWO) || (mul4 && fs <= FS_S5_MAX);
            FT_SINC3:    fsLegal = mul4;
            FT_SINC5AVG: fsLegal = mul4;
            default:     fsLegal = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] sincOrder(input logic [1:0] ft);
        sincOrder = (ft == FT_SINC3) ? ORDER_SINC3 : ORDER_SINC5;
    endfunction

    // Averaging mode pins the sinc stage at the base decimation
    function automatic logic [31:0] sincRate(input logic [1:0] ft, input logic [15:0] fs);
        if (ft == FT_SINC5AVG)
            sincRate = 32'(FS_AVG_BASE) * SINC_BASE;
        else
            sincRate = 32'(fs) * SINC_BASE;
    endfunction

    function automatic logic [31:0] procCycles(input logic [1:0] ft, input logic [15:0] fs,
                                               input logic full);
        procCycles = PT_SEQ;
        case (ft)
            FT_SINC5:
            begin
                if (full)
                    procCycles = (fs == FS_ONE) ? PT_S5_FS1 : (fs == FS_TWO) ? PT_S5_FS2 : PT_S5;
                else if (fs == FS_ONE || fs == FS_TWO)
                    procCycles = PT_SEQ_LOWFS;
                else
                    procCycles = PT_SEQ;
            end
            FT_SINC3:    procCycles = full ? PT_S3 : PT_SEQ;
            FT_SINC5AVG: procCycles = !full ? PT_SEQ : (fs == FS_AVG_BASE) ? PT_AVG_FS4 : PT_AVG;
            default:     procCycles = PT_SEQ;
        endcase
    endfunction

    // Sinc words combined into one output word, averaging and post filter together
    function automatic logic [31:0] groupSize(input logic [1:0] ft, input logic [15:0] fs,
                                              input logic [2:0] ps);
        logic [31:0] avg;
        logic [31:0] pw;
        avg = (ft == FT_SINC5AVG) ? 32'(fs / FS_AVG_BASE) : ONE32;
        case (ps)
            PS_40MS:  pw = POST40_WORDS;
            PS_50MS:  pw = POST50_WORDS;
            PS_60MS:  pw = POST60_WORDS;
            PS_AVG16: pw = AVG16_WORDS;
            default:  pw = ONE32;
        endcase
        groupSize = avg * pw;
    endfunction

    function automatic logic [5:0] ceilLog2(input logic [31:0] v);
        ceilLog2 = 6'h00;
        for (int i = 0; i < 32; i++)
        begin
            if ((ONE32 << i) < v)
                ceilLog2 = 6'(i + 1);
        end
    endfunction

    function automatic logic [CW-1:0] nextChan(input logic [NCH-1:0] m, input int start);
        logic found;
        int   idx;
        found    = 1'b0;
        nextChan = '0;
        for (int k = 0; k < NCH; k++)
        begin
            idx = (start + k) % NCH;
            if (!found && m[idx])
            begin
                found    = 1'b1;
                nextChan = CW'(idx);
            end
        end
    endfunction

    // A cleared mask idles the block; a manual channel keeps converting across writes
    function automatic sdpf_phase_t restartPhase(input logic anyOn, input logic idleNow);
        if (anyOn)
            restartPhase = ST_SETTLE;
        else if (idleNow)
            restartPhase = ST_IDLE;
        else
            restartPhase = ST_SETTLE;
    endfunction

    // Longest group is a full averaging run times the longest post filter
    localparam logic [15:0] FS_ALL    = '1;
    localparam logic [31:0] GROUP_MAX = 32'(FS_ALL / FS_AVG_BASE) * POST60_WORDS;

    initial
    begin
        if (ACC_BITS < OUT_BITS + int'(ceilLog2(GROUP_MAX)))
            $error("sdpf_filter: group accumulator too narrow");
    end

    always_comb
    begin
        logic                restart;
        logic                full;
        logic [CW-1:0]       rChan;
        logic [31:0]         ord;
        logic [31:0]         prod;
        logic [OUT_BITS-1:0] sincWord;
        logic [ACC_BITS-1:0] sum;
        logic [6:0]          shiftTotal;
        next_s           = s;
        ord              = '0;
        prod             = '0;
        shiftTotal       = '0;
        restart          = 1'b0;
        full             = 1'b1;
        rChan            = s.chan;
        next_s.clrCic    = 1'b0;
        next_s.decStb    = 1'b0;
        next_s.dataValid = 1'b0;
        sincWord         = OUT_BITS'($signed(cicResult) >>> s.sincShift);
        sum              = s.accum + ACC_BITS'($signed(sincWord));
        next_s.mask      = chanEnable;
        next_s.seq       = (chanEnable & (chanEnable - NCH'(1))) != '0;

        if (cfgWrite)
        begin
            if (fsLegal(cfgFilterType, cfgDecimation))
            begin
                next_s.fType  = cfgFilterType;
                next_s.fs     = cfgDecimation;
                next_s.post   = cfgPostSel;
                next_s.cfgErr = 1'b0;
                restart       = 1'b1;
                rChan         = next_s.seq ? nextChan(chanEnable, 0) : s.chan;
            end
            else
            begin
                next_s.cfgErr = 1'b1;
            end
        end

        if (chanSelWrite)
        begin
            restart = 1'b1;
            rChan   = chanSel;
        end
        else if (chanEnable != s.mask)
        begin
            restart = 1'b1;
            rChan   = nextChan(chanEnable, 0);
        end

        if (!restart && s.phase != ST_IDLE && modBitValid)
        begin
            if (s.decCnt == s.rate - ONE32)
            begin
                next_s.decCnt = '0;
                next_s.decStb = 1'b1;
            end
            else
            begin
                next_s.decCnt = s.decCnt + ONE32;
            end

            if (s.wordCnt == ONE32)
            begin
                next_s.wordCnt = s.rate;
                if (s.inGroup == s.group - ONE32)
                begin
                    next_s.inGroup   = '0;
                    next_s.accum     = '0;
                    next_s.dataValid = 1'b1;
                    next_s.dataWord  = OUT_BITS'($signed(sum) >>> s.grpShift);
                    next_s.dataChan  = s.chan;
                    next_s.phase     = ST_RUN;
                    if (s.seq)
                    begin
                        if (s.repLeft <= 8'h01)
                        begin
                            restart = 1'b1;
                            full    = 1'b0;
                            rChan   = nextChan(s.mask, (int'(s.chan) + 1) % NCH);
                        end
                        else
                        begin
                            next_s.repLeft = s.repLeft - 8'h01;
                        end
                    end
                end
                else
                begin
                    next_s.inGroup = s.inGroup + ONE32;
                    next_s.accum   = sum;
                end
            end
            else
            begin
                next_s.wordCnt = s.wordCnt - ONE32;
            end
        end

        // A restart reloads the whole settling schedule from the newest configuration
        if (restart)
        begin
            ord              = sincOrder(next_s.fType);
            next_s.rate      = sincRate(next_s.fType, next_s.fs);
            prod             = ord * next_s.rate;
            next_s.wordCnt   = prod + procCycles(next_s.fType, next_s.fs, full);
            next_s.group     = groupSize(next_s.fType, next_s.fs, next_s.post);
            next_s.grpShift  = ceilLog2(next_s.group);
            shiftTotal       = 7'(ord * 32'(ceilLog2(next_s.rate)));
            next_s.sincShift = (shiftTotal > 7'(OUT_BITS - 2)) ? shiftTotal - 7'(OUT_BITS - 2)
                                                               : 7'h00;
            next_s.decCnt    = '0;
            next_s.inGroup   = '0;
            next_s.accum     = '0;
            next_s.clrCic    = 1'b1;
            next_s.chan      = rChan;
            next_s.repLeft   = (chanRepeat == 8'h00) ? 8'h01 : chanRepeat;
            next_s.phase     = restartPhase(chanEnable != '0 || chanSelWrite,
                                            s.phase == ST_IDLE || chanEnable != s.mask);
        end
    end

    // Reset default is fifth-order sinc followed by averaging at the base decimation
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s         <= '0;
            s.phase   <= ST_IDLE;
            s.fType   <= FT_SINC5AVG;
            s.fs      <= FS_AVG_BASE;
            s.post    <= PS_NONE;
            s.rate    <= 32'(FS_AVG_BASE) * SINC_BASE;
            s.group   <= ONE32;
            s.repLeft <= 8'h01;
        end
        else
        begin
            s <= next_s;
        end
    end

    sdpf_cic #(
        .ACC_W       (CIC_ACC_BITS)
    ) u_cic (
        .clk         (clk),
        .rst         (rst),
        .clear       (s.clrCic),
        .order5      (s.fType != FT_SINC3),
        .decStrobe   (s.decStb),
        .sampleValid (modBitValid),
        .sampleBit   (modBit),
        .result      (cicResult)
    );

    assign dataValid        = s.dataValid;
    assign dataWord         = s.dataWord;
    assign dataChannel      = s.dataChan;
    assign cfgError         = s.cfgErr;
    assign seqActive        = s.seq;
    assign settling         = (s.phase == ST_SETTLE);
    assign activeFilterType = s.fType;
    assign activeDecimation = s.fs;
endmodule

// ---- sim/sdpf_filter_monitor.sv ----
// Checker for the sinc decimation and post filter block.
// Assumes it is bound to sdpf_filter and sees only its ports.
module sdpf_filter_monitor
    import sdpf_pkg::*;
#(
    parameter int NCH = 16,
    parameter int CW  = 4
)
(
    // Clock, reset and stream
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                modBitValid,
    input wire logic                modBit,
    // Configuration and channels
    input wire logic                cfgWrite,
    input wire logic [1:0]          cfgFilterType,
    input wire logic [15:0]         cfgDecimation,
    input wire logic [2:0]          cfgPostSel,
    input wire logic [NCH-1:0]      chanEnable,
    input wire logic [7:0]          chanRepeat,
    input wire logic                chanSelWrite,
    input wire logic [CW-1:0]       chanSel,
    // Outputs of the design
    input wire logic                dataValid,
    input wire logic [OUT_BITS-1:0] dataWord,
    input wire logic [CW-1:0]       dataChannel,
    input wire logic                cfgError,
    input wire logic                seqActive,
    input wire logic                settling,
    input wire logic [1:0]          activeFilterType,
    input wire logic [15:0]         activeDecimation
);
    logic legal;

    // Legality is recomputed here so a wrong acceptance test in the design shows up
    always_comb
    begin
        legal = (cfgDecimation[1:0] == 2'h0) && (cfgDecimation >= 16'h0004);
        if (cfgFilterType == FT_SINC5)
            legal = (cfgDecimation == 16'h0001) || (cfgDecimation == 16'h0002)
                || (legal && (cfgDecimation <= 16'h0100));
        if (cfgFilterType == 2'h3)
            legal = 1'b0;
    end

    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_VALID_PULSE: assert property (dataValid |=> !dataValid)
        else $error("dataValid high two cycles");
    AST_WORD_HOLD: assert property (!dataValid |-> $stable(dataWord) && $stable(dataChannel))
        else $error("word changed without dataValid");
    AST_CFG_ACCEPT: assert property (cfgWrite && legal |=> !cfgError
        && activeFilterType == $past(cfgFilterType) && activeDecimation == $past(cfgDecimation))
        else $error("legal setting not taken");
    AST_CFG_REFUSE: assert property (cfgWrite && !legal |=> cfgError
        && $stable(activeDecimation) && $stable(activeFilterType))
        else $error("illegal setting not refused");
    AST_CFG_HOLD: assert property (!cfgWrite |=> $stable(activeDecimation) && $stable(cfgError))
        else $error("setting changed without a write");
    AST_SEQ_ACTIVE: assert property (1'b1 |=> seqActive == ($countones($past(chanEnable)) > 1))
        else $error("seqActive wrong");
    AST_SELECT_SETTLE: assert property (chanSelWrite |=> settling)
        else $error("no settling after select");
    AST_CFG_SETTLE: assert property (cfgWrite && legal && (chanEnable != '0) |=> settling)
        else $error("no settling after setting write");
    AST_VALID_SETTLED: assert property (dataValid && !seqActive |-> !settling)
        else $error("word while settling");
endmodule

bind sdpf_filter sdpf_filter_monitor #(.NCH(NCH), .CW(CW)) u_sdpf_filter_monitor
(
    .clk(clk), .rst(rst), .modBitValid(modBitValid), .modBit(modBit),
    .cfgWrite(cfgWrite), .cfgFilterType(cfgFilterType), .cfgDecimation(cfgDecimation),
    .cfgPostSel(cfgPostSel), .chanEnable(chanEnable), .chanRepeat(chanRepeat),
    .chanSelWrite(chanSelWrite), .chanSel(chanSel), .dataValid(dataValid),
    .dataWord(dataWord), .dataChannel(dataChannel), .cfgError(cfgError),
    .seqActive(seqActive), .settling(settling), .activeFilterType(activeFilterType),
    .activeDecimation(activeDecimation)
);

// ---- sim/sdpf_mod_source.sv ----
// Modulator bitstream source, one tick per divided clock period.
// Assumes the bench picks prompt or slow ticking through slow.
module sdpf_mod_source
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Pace
    input  wire logic slow,
    // Bitstream
    output logic      modBitValid,
    output logic      modBit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] gap;

    always @(posedge clk)
    begin
        if (rst)
        begin
            gap <= 2'h0;
            modBitValid <= 1'b0;
            modBit <= 1'b0;
        end
        else
        begin
            gap <= (gap != 2'h0) ? gap - 2'h1 : (slow ? 2'h2 : 2'h0);
            modBitValid <= (gap == 2'h0);
            // Between ticks the bit toggles so a stale value is never mistaken for data
            modBit <= (gap == 2'h0) ? 1'($urandom) : ~modBit;
        end
    end
endmodule

// ---- sim/sdpf_filter_bench.sv ----
// Self-checking bench for the sinc decimation and post filter block.
// Assumes the modulator source model and the bound checker.
module sdpf_filter_bench
    import sdpf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0, cfgWrite = 1'b0, chanSelWrite = 1'b0;
    logic [1:0] cfgFilterType = 2'h0;
    logic [15:0] cfgDecimation = 16'h0004, chanEnable = 16'h0000;
    logic [2:0] cfgPostSel = 3'h0;
    logic [7:0] chanRepeat = 8'h01;
    logic [3:0] chanSel = 4'h0, dataChannel, ch;
    logic modBitValid, modBit, dataValid, cfgError, seqActive, settling;
    logic [OUT_BITS-1:0] dataWord;
    logic [1:0] activeFilterType;
    logic [15:0] activeDecimation, expDec;
    int n_fail = 0, n_checks = 0, cycles = 0, tickCount = 0, t, r, s;
    int lt[10] = '{1, 1, 1, 1, 1, 2, 2, 0, 3, 2};
    int ld[10] = '{1, 2, 3, 256, 260, 65532, 6, 4, 8, 0};
    int ft[10] = '{1, 1, 1, 2, 0, 0, 1, 1, 1, 1};
    int fd[10] = '{1, 2, 4, 4, 4, 8, 1, 1, 1, 1};
    int fp[10] = '{0, 0, 0, 0, 0, 0, 4, 1, 2, 3};

    sdpf_filter u_sdpf_filter (.clk(clk), .rst(rst), .modBitValid(modBitValid),
        .modBit(modBit), .cfgWrite(cfgWrite), .cfgFilterType(cfgFilterType),
        .cfgDecimation(cfgDecimation), .cfgPostSel(cfgPostSel), .chanEnable(chanEnable),
        .chanRepeat(chanRepeat), .chanSelWrite(chanSelWrite), .chanSel(chanSel),
        .dataValid(dataValid), .dataWord(dataWord), .dataChannel(dataChannel),
        .cfgError(cfgError), .seqActive(seqActive), .settling(settling),
        .activeFilterType(activeFilterType), .activeDecimation(activeDecimation));
    sdpf_mod_source u_sdpf_mod_source (.clk(clk), .rst(rst), .slow(slow),
        .modBitValid(modBitValid), .modBit(modBit));

    always #20 clk = ~clk;

    always @(posedge clk)
    begin
        if (modBitValid === 1'b1)
            tickCount <= tickCount + 1;
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            n_fail++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Ends two edges after the write so its effect is visible
    task automatic write_cfg(input int ty, input int d, input int ps, input logic sel);
        @(posedge clk);
        cfgWrite <= 1'b1;
        cfgFilterType <= 2'(ty);
        cfgDecimation <= 16'(d);
        cfgPostSel <= 3'(ps);
        chanSelWrite <= sel;
        chanSel <= ch;
        @(posedge clk);
        cfgWrite <= 1'b0;
        chanSelWrite <= 1'b0;
        @(posedge clk);
    endtask

    // Ticks counted after the restart edge up to the completing tick
    task automatic wait_word(output int n);
        int b;
        b = tickCount;
        @(posedge clk);
        for (int i = 0; i < 50000 && dataValid !== 1'b1; i++)
            @(posedge clk);
        n = tickCount - b;
    endtask

    function automatic int rate(input int ty, input int d);
        return (ty == 0) ? 128 : 32 * d;
    endfunction

    function automatic int group(input int ty, input int d, input int ps);
        int w;
        w = (ps == 1) ? 48 : (ps == 2) ? 60 : (ps == 3) ? 72 : (ps == 4) ? 16 : 1;
        return w * ((ty == 0) ? d / 4 : 1);
    endfunction

    function automatic int first_ticks(input int ty, input int d, input int ps);
        int pt;
        pt = (ty == 2) ? 92 : (ty == 1) ? (d == 1 ? 98 : d == 2 ? 114 : 96) : (d == 4 ? 96 : 98);
        return ((ty == 2) ? 3 : 5) * rate(ty, d) + pt + (group(ty, d, ps) - 1) * rate(ty, d);
    endfunction

    initial
    begin
        void'($urandom(10793));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        check("type after reset", activeFilterType, FT_SINC5AVG);
        check("dec after reset", activeDecimation, 32'h0000_0004);
        expDec = 16'h0004;
        ld[9] = (($urandom % 16383) + 1) * 4;
        for (int k = 0; k < 10; k++)
        begin
            write_cfg(lt[k], ld[k], 0, 1'b0);
            if (k == 0 || k == 1 || k == 3 || k == 5 || k == 7 || k == 9)
                expDec = 16'(ld[k]);
            check("cfgError", cfgError, (expDec == 16'(ld[k])) ? 0 : 1);
            check("activeDecimation", activeDecimation, expDec);
        end
        $display("test config legality done");
        for (int k = 0; k < 10; k++)
        begin
            ch = 4'($urandom);
            write_cfg(2, 8, 0, 1'b1);
            repeat ($urandom % 8) @(posedge clk);
            write_cfg(ft[k], fd[k], fp[k], 1'b1);
            wait_word(t);
            check("first word ticks", t, first_ticks(ft[k], fd[k], fp[k]));
            check("word channel", dataChannel, ch);
            wait_word(t);
            check("word period", t, group(ft[k], fd[k], fp[k]) * rate(ft[k], fd[k]));
        end
        $display("test settling and rate done");
        slow <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            chanEnable <= 16'h0000;
            write_cfg(ft[k * 3 % 4 + 2 - k], fd[k * 3 % 4 + 2 - k], 0, 1'b0);
            t = ft[k * 3 % 4 + 2 - k];
            r = rate(t, fd[k * 3 % 4 + 2 - k]);
            s = ((t == 2) ? 3 : 5) * r + ((t == 1 && r <= 64) ? 64 : 0);
            @(posedge clk);
            chanEnable <= 16'h0006;
            chanRepeat <= 8'h02;
            @(posedge clk);
            @(posedge clk);
            for (int w = 0; w < 5; w++)
            begin
                wait_word(t);
                check("seq ticks", t, (w == 0) ? first_ticks(ft[k * 3 % 4 + 2 - k],
                    fd[k * 3 % 4 + 2 - k], 0) : (w % 2 == 1) ? r : s);
                check("seq channel", dataChannel, (w == 2 || w == 3) ? 2 : 1);
            end
            check("seqActive", seqActive, 1);
        end
        $display("test sequencer done");
        write_cfg(3, 8, 0, 1'b0);
        check("cfgError before reset", cfgError, 1);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        check("dec after second reset", activeDecimation, 32'h0000_0004);
        check("error after second reset", cfgError, 0);
        $display("test second reset done");
        finish_test();
    end
endmodule
